// File: design/rate_select_routing_alarm_flags.sv
/*
 * Rate-select routing and alarm status registers of a fibre-module
 * management controller.
 * Assumes the serial interface decodes host transfers into single-cycle
 * byte read and write strobes, and the converter presents each result with
 * a one-cycle valid pulse beside its threshold pair.
 */
`timescale 1ns/1ps

module rate_select_routing_alarm_flags (
	input wire logic ref_clk, // 125 MHz clock
	input wire logic rst_n, // Synchronous reset, low
	input wire logic [7:0] reg_addr, // Byte address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, next cycle
	input wire logic rx_rate_input_pin, // Receive rate pin
	input wire logic tx_rate_input_pin, // Transmit rate pin
	output logic rx_rate_output, // Receive rate select out
	output logic tx_rate_output, // Transmit rate select out
	input wire logic [4:0] meas_valid, // New result per parameter
	input wire logic [79:0] meas_value, // Five 16-bit results
	input wire logic [79:0] upper_limit, // Five maximum thresholds
	input wire logic [79:0] lower_limit // Five minimum thresholds
);

	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	logic [7:0] app_select_reg;
	logic soft_rx_rate_bit;
	logic soft_tx_rate_bit;
	logic [rate_alarm_pkg::PARAM_COUNT-1:0] high_flag_reg;
	logic [rate_alarm_pkg::PARAM_COUNT-1:0] low_flag_reg;
	logic [rate_alarm_pkg::PARAM_COUNT-1:0] seen_reg;
	logic conv_done_reg;
	logic [7:0] alarm_status_low;
	logic [7:0] alarm_status_high;
	rate_alarm_pkg::rate_mode_type mode_field;
	logic rx_next;
	logic tx_next;

	assign mode_field = rate_alarm_pkg::rate_mode_type'(
		app_select_reg[rate_alarm_pkg::MODE_MSB:rate_alarm_pkg::MODE_LSB]);

	// Host writes; the alarm bytes ignore writes since they are status only
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			app_select_reg <= rate_alarm_pkg::APP_SELECT_RESET;
			soft_rx_rate_bit <= rate_alarm_pkg::SOFT_BIT_RESET;
			soft_tx_rate_bit <= rate_alarm_pkg::SOFT_BIT_RESET;
		end else if (reg_wr) begin
			if (reg_addr == rate_alarm_pkg::ADDR_APP_SELECT) begin
				app_select_reg <= reg_wdata;
			end
			if (reg_addr == rate_alarm_pkg::ADDR_CONTROL) begin
				soft_rx_rate_bit <= reg_wdata[rate_alarm_pkg::SOFT_RATE_POS];
			end
			if (reg_addr == rate_alarm_pkg::ADDR_EXT_CONTROL) begin
				soft_tx_rate_bit <= reg_wdata[rate_alarm_pkg::SOFT_RATE_POS];
			end
		end
	end

	// ----------------------------------------------------------------
	// Rate-select routing
	// ----------------------------------------------------------------

	// Output source per mode; every code is legal so no default
	always_comb begin
		unique case (mode_field)
			rate_alarm_pkg::MODE_EMULATION: begin
				rx_next = rx_rate_input_pin | soft_rx_rate_bit;
				tx_next = soft_tx_rate_bit;
			end
			rate_alarm_pkg::MODE_HARDWARE: begin
				rx_next = rx_rate_input_pin;
				tx_next = tx_rate_input_pin;
			end
			rate_alarm_pkg::MODE_SOFTWARE,
			rate_alarm_pkg::MODE_SOFTWARE_ALT: begin
				rx_next = rate_alarm_pkg::SOFTWARE_MODE_LEVEL;
				tx_next = rate_alarm_pkg::SOFTWARE_MODE_LEVEL;
			end
		endcase
	end

	// Registered so the pins never glitch while the mode byte changes
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_rate_output <= rate_alarm_pkg::SOFTWARE_MODE_LEVEL;
			tx_rate_output <= rate_alarm_pkg::SOFTWARE_MODE_LEVEL;
		end else begin
			rx_rate_output <= rx_next;
			tx_rate_output <= tx_next;
		end
	end

	// ----------------------------------------------------------------
	// Alarm comparison
	// ----------------------------------------------------------------

	// One comparator pair per parameter; temperature is two's complement
	genvar gi;
	generate
		for (gi = 0; gi < rate_alarm_pkg::PARAM_COUNT; gi++) begin : g_param
			logic [15:0] value;
			logic [15:0] upper;
			logic [15:0] lower;
			logic above;
			logic below;
			assign value = meas_value[gi*16 +: 16];
			assign upper = upper_limit[gi*16 +: 16];
			assign lower = lower_limit[gi*16 +: 16];
			if (gi == rate_alarm_pkg::PARAM_TEMP) begin : g_signed
				assign above = $signed(value) > $signed(upper);
				assign below = $signed(value) < $signed(lower);
			end else begin : g_unsigned
				assign above = value > upper;
				assign below = value < lower;
			end
			// Flags follow the latest result, set and cleared alike
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					high_flag_reg[gi] <= 1'b0;
					low_flag_reg[gi] <= 1'b0;
					seen_reg[gi] <= 1'b0;
				end else if (meas_valid[gi]) begin
					high_flag_reg[gi] <= above;
					low_flag_reg[gi] <= below;
					seen_reg[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// First full cycle is done once every parameter has reported once
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			conv_done_reg <= 1'b0;
		end else if (seen_reg == rate_alarm_pkg::ALL_SEEN) begin
			conv_done_reg <= 1'b1;
		end
	end

	// Byte images; flags stay hidden until the first cycle completes
	assign alarm_status_low = conv_done_reg ? {
		high_flag_reg[rate_alarm_pkg::PARAM_TEMP],
		low_flag_reg[rate_alarm_pkg::PARAM_TEMP],
		high_flag_reg[rate_alarm_pkg::PARAM_VOLT],
		low_flag_reg[rate_alarm_pkg::PARAM_VOLT],
		high_flag_reg[rate_alarm_pkg::PARAM_BIAS],
		low_flag_reg[rate_alarm_pkg::PARAM_BIAS],
		high_flag_reg[rate_alarm_pkg::PARAM_TXPOWER],
		low_flag_reg[rate_alarm_pkg::PARAM_TXPOWER]
	} : rate_alarm_pkg::ALARM_RESET;
	assign alarm_status_high = conv_done_reg ? {
		high_flag_reg[rate_alarm_pkg::PARAM_RXPOWER],
		low_flag_reg[rate_alarm_pkg::PARAM_RXPOWER],
		rate_alarm_pkg::ALARM_HIGH_RESERVED
	} : rate_alarm_pkg::ALARM_RESET;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------

	// Unmapped bytes and unused bits of the shared bytes read as zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata <= rate_alarm_pkg::READ_ZERO;
		end else if (reg_rd) begin
			unique case (reg_addr)
				rate_alarm_pkg::ADDR_APP_SELECT:
					reg_rdata <= app_select_reg;
				rate_alarm_pkg::ADDR_ALARM_LOW:
					reg_rdata <= alarm_status_low;
				rate_alarm_pkg::ADDR_ALARM_HIGH:
					reg_rdata <= alarm_status_high;
				rate_alarm_pkg::ADDR_CONTROL:
					reg_rdata <= {4'h0, soft_rx_rate_bit, 3'h0};
				rate_alarm_pkg::ADDR_EXT_CONTROL:
					reg_rdata <= {4'h0, soft_tx_rate_bit, 3'h0};
				default:
					reg_rdata <= rate_alarm_pkg::READ_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_write_app;
		reg_wr && reg_addr == rate_alarm_pkg::ADDR_APP_SELECT;
	endsequence
	sequence s_read_app;
		reg_rd && !reg_wr && reg_addr == rate_alarm_pkg::ADDR_APP_SELECT;
	endsequence
	sequence s_read_high;
		reg_rd && reg_addr == rate_alarm_pkg::ADDR_ALARM_HIGH;
	endsequence

	a_app_readback: assert property (
		s_write_app ##1 !reg_wr ##1 s_read_app |=>
		reg_rdata == $past(reg_wdata, 3))
		else $error("application select byte did not read back");
	a_emul_rx_route: assert property (
		mode_field == rate_alarm_pkg::MODE_EMULATION |=>
		rx_rate_output == $past(rx_rate_input_pin | soft_rx_rate_bit))
		else $error("emulation receive rate output wrong");
	a_emul_tx_route: assert property (
		mode_field == rate_alarm_pkg::MODE_EMULATION |=>
		tx_rate_output == $past(soft_tx_rate_bit))
		else $error("emulation transmit rate output wrong");
	a_hw_pin_route: assert property (
		mode_field == rate_alarm_pkg::MODE_HARDWARE |=>
		rx_rate_output == $past(rx_rate_input_pin) &&
		tx_rate_output == $past(tx_rate_input_pin))
		else $error("hardware mode outputs do not follow pins");
	a_sw_hold_level: assert property (
		app_select_reg[rate_alarm_pkg::MODE_MSB] [*2] |->
		rx_rate_output == rate_alarm_pkg::SOFTWARE_MODE_LEVEL &&
		tx_rate_output == rate_alarm_pkg::SOFTWARE_MODE_LEVEL)
		else $error("software mode outputs not held");
	a_reserved_zero: assert property (
		s_read_high |=> reg_rdata[5:0] == rate_alarm_pkg::ALARM_HIGH_RESERVED)
		else $error("reserved alarm bits not zero");
	a_no_early_flag: assert property (
		seen_reg != rate_alarm_pkg::ALL_SEEN |=>
		alarm_status_low == rate_alarm_pkg::ALARM_RESET &&
		alarm_status_high == rate_alarm_pkg::ALARM_RESET)
		else $error("alarm flag set before first conversion");
	a_temp_high_flag: assert property (
		conv_done_reg && meas_valid[rate_alarm_pkg::PARAM_TEMP] |=>
		alarm_status_low[7] == $past(g_param[0].above))
		else $error("temperature high alarm wrong");
	a_rx_low_flag: assert property (
		conv_done_reg && meas_valid[rate_alarm_pkg::PARAM_RXPOWER] |=>
		alarm_status_high[6] == $past(g_param[4].below))
		else $error("receive power low alarm wrong");
	a_flag_holds: assert property (
		conv_done_reg && meas_valid == rate_alarm_pkg::NONE_SEEN |=>
		$stable(alarm_status_low) && $stable(alarm_status_high))
		else $error("alarm changed without a new result");

endmodule

// File: design/rate_alarm_pkg.sv
/*
 * Constants, register map and mode codes for the rate-select routing and
 * alarm flag register block.
 * Assumes a byte-wide register port behind the serial management interface.
 */
package rate_alarm_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h6E;
	localparam logic [7:0] ADDR_APP_SELECT = 8'h6F;
	localparam logic [7:0] ADDR_ALARM_LOW = 8'h70;
	localparam logic [7:0] ADDR_ALARM_HIGH = 8'h71;
	localparam logic [7:0] ADDR_EXT_CONTROL = 8'h76;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int SOFT_RATE_POS = 3;
	localparam int MODE_MSB = 7;
	localparam int MODE_LSB = 6;
	localparam logic [7:0] APP_SELECT_RESET = 8'h00;
	localparam logic [7:0] ALARM_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [5:0] ALARM_HIGH_RESERVED = 6'h00;
	localparam logic SOFT_BIT_RESET = 1'b0;
	localparam logic SOFTWARE_MODE_LEVEL = 1'b0;

	// ----------------------------------------------------------------
	// Measured parameters
	// ----------------------------------------------------------------
	localparam int PARAM_COUNT = 5;
	localparam int MEAS_WIDTH = 16;
	localparam int PARAM_TEMP = 0;
	localparam int PARAM_VOLT = 1;
	localparam int PARAM_BIAS = 2;
	localparam int PARAM_TXPOWER = 3;
	localparam int PARAM_RXPOWER = 4;
	localparam logic [PARAM_COUNT-1:0] ALL_SEEN = 5'h1F;
	localparam logic [PARAM_COUNT-1:0] NONE_SEEN = 5'h00;

	// ----------------------------------------------------------------
	// Rate-select routing modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_EMULATION = 2'b00,
		MODE_HARDWARE = 2'b01,
		MODE_SOFTWARE = 2'b10,
		MODE_SOFTWARE_ALT = 2'b11
	} rate_mode_type;

endpackage

// File: bench/host_model.sv
/* Host model: single-byte register writes and reads on the strobe port.
 * Assumes the bench clock and a released reset. */
`timescale 1ns/1ps

module host_model (
	input wire logic ref_clk, // Bench clock
	output logic [7:0] reg_addr, // Byte address
	output logic [7:0] reg_wdata, // Write data
	output logic reg_wr, // Write strobe
	output logic reg_rd // Read strobe
);
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// Idle data is inverted so a stale byte is never taken for good
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'hFF;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Soft rate bits reach the device only through this write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// One-cycle read strobe; the answer is watched by the bench
	task automatic rd(input logic [7:0] a);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
	endtask
endmodule

// File: bench/test_rate_select_routing_alarm_flags.sv
/* Testbench: rate routing in all modes and alarm flag evaluation.
 * Assumes host_model drives the register port at falling edges. */
`timescale 1ns/1ps

`define CHK(nm, ex, got) \
	begin \
		compares++; \
		if ((got) !== (ex)) begin \
			err_count++; \
			$display("Error %s expected %h seen %h", nm, ex, got); \
		end \
	end

module test_rate_select_routing_alarm_flags;
	logic ref_clk, rst_n, reg_wr, reg_rd, rd_seen;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic rx_rate_input_pin, tx_rate_input_pin, rx_rate_output, tx_rate_output;
	logic [4:0] meas_valid, flag_hi, flag_lo;
	logic [79:0] meas_value, upper_limit, lower_limit;
	logic [7:0] exp_q[$];
	logic [7:0] exp_v;
	int err_count, compares;

	host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	rate_select_routing_alarm_flags dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_rate_input_pin(rx_rate_input_pin),
		.tx_rate_input_pin(tx_rate_input_pin),
		.rx_rate_output(rx_rate_output), .tx_rate_output(tx_rate_output),
		.meas_valid(meas_valid), .meas_value(meas_value),
		.upper_limit(upper_limit), .lower_limit(lower_limit));

	// ----------------------------------------
	// Clock, read watcher, watchdog
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// Read data lands one cycle after the strobe edge
	// Oldest note is taken once, so a mismatch print cannot pop a second one
	always @(posedge ref_clk) rd_seen <= reg_rd;
	always @(negedge ref_clk) begin
		if (rd_seen === 1'b1) begin
			exp_v = exp_q.pop_front();
			`CHK("read data", exp_v, reg_rdata)
		end
	end
	// Whole run is about 1200 cycles; this leaves ample margin
	initial begin
		#60000;
		err_count++;
		give_verdict();
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic give_verdict();
		if (err_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic expect_read(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_u.rd(a);
	endtask
	// Random results near the limits so equality cases occur;
	// temperature goes negative to exercise the signed compare
	task automatic meas(input logic [4:0] vld);
		logic signed [16:0] v, u, l;
		@(negedge ref_clk);
		for (int p = 0; p < 5; p++) begin
			v = 17'($urandom_range(8)) - 17'((p == 0) ? 4 : 0);
			u = 17'($urandom_range(6));
			l = 17'($urandom_range(3)) - 17'((p == 0) ? 2 : 0);
			meas_value[16*p +: 16] = v[15:0];
			upper_limit[16*p +: 16] = u[15:0];
			lower_limit[16*p +: 16] = l[15:0];
			if (vld[p]) begin
				flag_hi[p] = v > u;
				flag_lo[p] = v < l;
			end
		end
		meas_valid = vld;
		@(negedge ref_clk);
		meas_valid = 5'h00;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [1:0] mode;
		logic [3:0] c;
		logic [7:0] r, soft_rx_img, soft_tx_img;
		logic ex_rx, ex_tx;
		void'($urandom(9));
		rst_n = 1'b0;
		rx_rate_input_pin = 1'b0;
		tx_rate_input_pin = 1'b0;
		meas_valid = 5'h00;
		meas_value = '0;
		upper_limit = '0;
		lower_limit = '0;
		flag_hi = 5'h00;
		flag_lo = 5'h00;
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		// Read-only and unmapped writes are dropped
		host_u.wr(rate_alarm_pkg::ADDR_ALARM_LOW, 8'hFF);
		host_u.wr(8'h85, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			expect_read(8'h6F + 8'(i == 3 ? 8'h16 : i), 8'h00);
		end
		// Every mode against every pin and soft bit combination
		for (int i = 0; i < 64; i++) begin
			mode = i[5:4];
			c = i[3:0];
			r = 8'($urandom);
			host_u.wr(rate_alarm_pkg::ADDR_CONTROL, {r[7:4], c[0], r[2:0]});
			host_u.wr(rate_alarm_pkg::ADDR_EXT_CONTROL, {r[3:0], c[1], r[6:4]});
			host_u.wr(rate_alarm_pkg::ADDR_APP_SELECT, {mode, r[5:0]});
			rx_rate_input_pin = c[2];
			tx_rate_input_pin = c[3];
			expect_read(rate_alarm_pkg::ADDR_APP_SELECT, {mode, r[5:0]});
			// Only the soft bit survives in its byte; the rest reads zero
			soft_rx_img = 8'(c[0]) << rate_alarm_pkg::SOFT_RATE_POS;
			soft_tx_img = 8'(c[1]) << rate_alarm_pkg::SOFT_RATE_POS;
			expect_read(rate_alarm_pkg::ADDR_CONTROL, soft_rx_img);
			expect_read(rate_alarm_pkg::ADDR_EXT_CONTROL, soft_tx_img);
			repeat (2) @(negedge ref_clk);
			ex_rx = mode[1] ? rate_alarm_pkg::SOFTWARE_MODE_LEVEL :
				(mode[0] ? c[2] : (c[2] | c[0]));
			ex_tx = mode[1] ? rate_alarm_pkg::SOFTWARE_MODE_LEVEL :
				(mode[0] ? c[3] : c[1]);
			`CHK("rx rate", ex_rx, rx_rate_output)
			`CHK("tx rate", ex_tx, tx_rate_output)
		end
		// Four of five results in: flags still held at zero
		meas(5'h0F);
		@(negedge ref_clk);
		expect_read(rate_alarm_pkg::ADDR_ALARM_LOW, 8'h00);
		// Last first result, then random subsets re-evaluated
		for (int i = 0; i < 30; i++) begin
			meas((i == 0) ? 5'h10 : 5'($urandom));
			// Host writes to the status bytes must not disturb the flags
			host_u.wr(rate_alarm_pkg::ADDR_ALARM_LOW + 8'(i % 2), 8'($urandom));
			@(negedge ref_clk);
			expect_read(rate_alarm_pkg::ADDR_ALARM_LOW, {flag_hi[0], flag_lo[0],
				flag_hi[1], flag_lo[1], flag_hi[2], flag_lo[2], flag_hi[3],
				flag_lo[3]});
			expect_read(rate_alarm_pkg::ADDR_ALARM_HIGH,
				{flag_hi[4], flag_lo[4], 6'h00});
		end
		// Mid-run reset: mode, soft bits and flags fall back to reset values
		rst_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		ex_rx = rx_rate_input_pin | rate_alarm_pkg::SOFT_BIT_RESET;
		ex_tx = rate_alarm_pkg::SOFT_BIT_RESET;
		`CHK("rx after reset", ex_rx, rx_rate_output)
		`CHK("tx after reset", ex_tx, tx_rate_output)
		expect_read(rate_alarm_pkg::ADDR_ALARM_LOW, rate_alarm_pkg::ALARM_RESET);
		expect_read(rate_alarm_pkg::ADDR_APP_SELECT,
			rate_alarm_pkg::APP_SELECT_RESET);
		repeat (3) @(negedge ref_clk);
		give_verdict();
	end
endmodule
